// [cpd_top.sv]
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module cpd_top #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_clk,
   input wire cpd_pkg::cpd_col_t col_pins,
   input wire cpd_pkg::cpd_ext_t ext_pins,
   input wire logic [7:0] dq_a_in,
   input wire logic [7:0] dq_b_in,
   output logic [7:0] dq_a_out,
   output logic [7:0] dq_b_out,
   output logic dq_oe_n,
   output logic [31:0] prech_banks,
   output logic cal_drive,
   output logic cal_sample,
   output logic standby
);
   localparam int AW = cpd_pkg::BANK_W + cpd_pkg::COL_W;
   localparam int DW = cpd_pkg::PKT_BYTES * cpd_pkg::BYTE_W;

   function automatic logic [31:0] onehot(input logic [4:0] b);
      onehot = 32'h1 << b;
   endfunction : onehot

   // pins are asynchronous to aclk: two flops each, three for link_clk, nothing reads stage one
   logic [2:0] lclk_s;
   cpd_pkg::cpd_col_t col_s1, col_s2;
   cpd_pkg::cpd_ext_t ext_s1, ext_s2;
   logic [7:0] dqa_s1, dqa_s2, dqb_s1, dqb_s2;

   always_ff @(posedge aclk)
   begin
      lclk_s <= {lclk_s[1:0], link_clk};
      col_s1 <= col_pins;
      col_s2 <= col_s1;
      ext_s1 <= ext_pins;
      ext_s2 <= ext_s1;
      dqa_s1 <= dq_a_in;
      dqa_s2 <= dqa_s1;
      dqb_s1 <= dq_b_in;
      dqb_s2 <= dqb_s1;
   end

   wire tick = lclk_s[1] && !lclk_s[2];

   // registers
   logic [4:0] own_id_r;
   logic [3:0] rd_dly_r, wr_dly_r;
   logic [31:0] prech_last_r;
   cpd_pkg::cpd_pwr_t pwr_r;

   // packet decode
   wire in_attention = (pwr_r == cpd_pkg::CPD_ATTENTION);
   wire col_go = tick && in_attention && col_s2.start;
   wire col_hit = col_go && (col_s2.column_device_field == own_id_r);
   wire [2:0] cop = col_s2.column_opcode[2:0];
   wire c_wr = col_hit && (cop == cpd_pkg::COP_WRITE || cop == cpd_pkg::COP_WRITE_AP);
   wire c_rd = col_hit && (cop == cpd_pkg::COP_READ || cop == cpd_pkg::COP_READ_AP);
   wire c_pre = col_hit && (cop == cpd_pkg::COP_PRECH);
   wire c_rd_ap = col_hit && (cop == cpd_pkg::COP_READ_AP);
   wire c_rlx = col_hit && col_s2.column_opcode[cpd_pkg::COP_RELAX_BIT];
   wire x_byte_en = col_go && ext_s2.mask_select;
   wire [4:0] xop = ext_s2.extended_opcode;
   // reserved low bit and 00000 fall through every term below
   wire x_hit = col_go && !ext_s2.mask_select && !xop[cpd_pkg::XOP_RSV_BIT]
      && (ext_s2.extended_device_field == own_id_r);
   wire x_pre = x_hit && xop[cpd_pkg::XOP_PRECH_BIT];
   // drive alone for x10x0, drive and latch the new setting for x11x0
   wire x_cal = x_hit && xop[cpd_pkg::XOP_CAL_BIT];
   wire x_upd = x_cal && xop[cpd_pkg::XOP_UPDATE_BIT];
   wire x_rlx = x_hit && xop[cpd_pkg::XOP_RELAX_BIT];

   // write buffer
   logic wb_valid_r, wb_full_r, wb_ap_r;
   logic [4:0] wb_bank_r;
   logic [6:0] wb_col_r;
   logic [DW-1:0] wb_data_r;
   // retire needs captured data; a half-filled buffer is left alone
   wire retire = col_go && wb_valid_r && wb_full_r;
   wire [15:0] mem_be = x_byte_en ? {ext_s2.lane_b_byte_enables,
      ext_s2.lane_a_byte_enables} : 16'hFFFF;
   wire [AW-1:0] rd_addr = {col_s2.column_bank_field, col_s2.column_address_field};
   logic [DW-1:0] mem_rdata;

   cpd_mem #(.AW(AW), .NB(cpd_pkg::PKT_BYTES)) u_mem (
      .aclk(aclk),
      .we(retire),
      .be(mem_be),
      .waddr({wb_bank_r, wb_col_r}),
      .wdata(wb_data_r),
      .re(c_rd),
      .raddr(rd_addr),
      .rdata(mem_rdata)
   );

   // write data capture
   cpd_pkg::cpd_xfer_t wr_st_r;
   logic [3:0] wr_cnt_r;
   logic [2:0] wr_idx_r;
   wire wr_take = tick && ((wr_st_r == cpd_pkg::CPD_WAIT && wr_cnt_r == 4'h1)
      || wr_st_r == cpd_pkg::CPD_MOVE);
   wire [2:0] wr_beat = (wr_st_r == cpd_pkg::CPD_MOVE) ? wr_idx_r : 3'h0;
   wire wr_last = wr_take && wr_beat == 3'(cpd_pkg::BEATS - 1);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_st_r <= cpd_pkg::CPD_IDLE;
         wr_cnt_r <= 4'h0;
         wr_idx_r <= 3'h0;
         wb_valid_r <= 1'b0;
         wb_full_r <= 1'b0;
         wb_ap_r <= 1'b0;
         wb_bank_r <= 5'h00;
         wb_col_r <= 7'h00;
         wb_data_r <= '0;
      end
      else if (c_wr)
      begin
         wb_valid_r <= 1'b1;
         wb_full_r <= 1'b0;
         wb_ap_r <= cop[2];
         wb_bank_r <= col_s2.column_bank_field;
         wb_col_r <= col_s2.column_address_field;
         wr_st_r <= cpd_pkg::CPD_WAIT;
         wr_cnt_r <= (wr_dly_r < cpd_pkg::WR_DLY_MIN) ? cpd_pkg::WR_DLY_MIN : wr_dly_r;
      end
      else
      begin
         if (retire)
         begin
            wb_valid_r <= 1'b0;
         end
         case (wr_st_r)
            cpd_pkg::CPD_IDLE:
            begin
               wr_idx_r <= 3'h0;
            end
            cpd_pkg::CPD_WAIT, cpd_pkg::CPD_MOVE:
            begin
               if (tick && wr_st_r == cpd_pkg::CPD_WAIT)
               begin
                  wr_cnt_r <= wr_cnt_r - 4'h1;
               end
               if (wr_take)
               begin
                  wb_data_r[wr_beat*8 +: 8] <= dqa_s2;
                  wb_data_r[(wr_beat+4'(cpd_pkg::BEATS))*8 +: 8] <= dqb_s2;
                  wr_idx_r <= wr_beat + 3'h1;
                  wr_st_r <= wr_last ? cpd_pkg::CPD_IDLE : cpd_pkg::CPD_MOVE;
                  wb_full_r <= wr_last;
               end
            end
            default:
            begin
               wr_st_r <= cpd_pkg::CPD_IDLE;
            end
         endcase
      end
   end

   // read data return; one packet in flight, reads arriving before it is done are dropped
   cpd_pkg::cpd_xfer_t rd_st_r;
   logic [3:0] rd_cnt_r;
   logic [2:0] rd_idx_r;
   logic rd_load_r;
   logic [DW-1:0] rd_data_r;
   wire [3:0] rd_dly = (rd_dly_r < cpd_pkg::RD_DLY_MIN) ? cpd_pkg::RD_DLY_MIN :
      (rd_dly_r > cpd_pkg::RD_DLY_MAX) ? cpd_pkg::RD_DLY_MAX : rd_dly_r;
   wire rd_start = tick && rd_st_r == cpd_pkg::CPD_WAIT && rd_cnt_r == 4'h1;
   wire rd_step = tick && rd_st_r == cpd_pkg::CPD_MOVE;
   wire [2:0] rd_beat = rd_start ? 3'h0 : rd_idx_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_st_r <= cpd_pkg::CPD_IDLE;
         rd_cnt_r <= 4'h0;
         rd_idx_r <= 3'h0;
         rd_load_r <= 1'b0;
         rd_data_r <= '0;
         dq_a_out <= 8'h00;
         dq_b_out <= 8'h00;
         dq_oe_n <= 1'b1;
      end
      else
      begin
         // a refused read must not overwrite the packet still being sent
         rd_load_r <= c_rd && rd_st_r == cpd_pkg::CPD_IDLE;
         if (rd_load_r)
         begin
            rd_data_r <= mem_rdata;
         end
         case (rd_st_r)
            cpd_pkg::CPD_IDLE:
            begin
               if (c_rd)
               begin
                  rd_st_r <= cpd_pkg::CPD_WAIT;
                  rd_cnt_r <= rd_dly;
               end
            end
            cpd_pkg::CPD_WAIT:
            begin
               if (tick)
               begin
                  rd_cnt_r <= rd_cnt_r - 4'h1;
               end
               if (rd_start)
               begin
                  rd_st_r <= cpd_pkg::CPD_MOVE;
               end
            end
            cpd_pkg::CPD_MOVE:
            begin
               // the index wraps to zero once the last beat is out
               if (rd_step && rd_idx_r == 3'h0)
               begin
                  rd_st_r <= cpd_pkg::CPD_IDLE;
               end
            end
            default:
            begin
               rd_st_r <= cpd_pkg::CPD_IDLE;
            end
         endcase
         if (rd_start || (rd_step && rd_idx_r != 3'h0))
         begin
            dq_a_out <= rd_data_r[rd_beat*8 +: 8];
            dq_b_out <= rd_data_r[(rd_beat+4'(cpd_pkg::BEATS))*8 +: 8];
            rd_idx_r <= rd_beat + 3'h1;
            dq_oe_n <= 1'b0;
         end
         else if (rd_step)
         begin
            dq_oe_n <= 1'b1;
         end
      end
   end

   // precharge, calibration and power state
   wire [31:0] pre_nxt = (c_pre || c_rd_ap ? onehot(col_s2.column_bank_field) : 32'h0)
      | (retire && wb_ap_r ? onehot(wb_bank_r) : 32'h0)
      | (x_pre ? onehot(ext_s2.extended_bank_field) : 32'h0);

   // axi write side
   logic aw_full_r, w_full_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   wire wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && aw_addr_r == ADDR_W'(cpd_pkg::REG_CTRL);
   wire wr_tim = wr_fire && aw_addr_r == ADDR_W'(cpd_pkg::REG_TIMING);
   wire wr_ok = wr_ctrl || wr_tim || aw_addr_r == ADDR_W'(cpd_pkg::REG_STATUS)
      || aw_addr_r == ADDR_W'(cpd_pkg::REG_PRECH);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         own_id_r <= cpd_pkg::OWN_ID_RST;
         rd_dly_r <= cpd_pkg::RD_DLY_RST;
         wr_dly_r <= cpd_pkg::WR_DLY_RST;
         pwr_r <= cpd_pkg::CPD_STANDBY;
         prech_banks <= 32'h0;
         prech_last_r <= 32'h0;
         cal_drive <= 1'b0;
         cal_sample <= 1'b0;
         standby <= 1'b1;
      end
      else
      begin
         prech_banks <= pre_nxt;
         if (pre_nxt != 32'h0)
         begin
            prech_last_r <= pre_nxt;
         end
         cal_drive <= x_cal;
         cal_sample <= x_upd;
         if (wr_ctrl && s_axi_wstrb[0])
         begin
            own_id_r <= w_data_r[4:0];
         end
         if (wr_tim && s_axi_wstrb[0])
         begin
            rd_dly_r <= w_data_r[3:0];
            wr_dly_r <= w_data_r[cpd_pkg::TIM_WR_LSB +: 4];
         end
         // relax from a packet wins over a wake request in the same cycle
         if (c_rlx || x_rlx)
         begin
            pwr_r <= cpd_pkg::CPD_STANDBY;
            standby <= 1'b1;
         end
         else if (wr_ctrl && s_axi_wstrb[1] && w_data_r[cpd_pkg::CTRL_WAKE_BIT])
         begin
            pwr_r <= cpd_pkg::CPD_ATTENTION;
            standby <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cpd_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? cpd_pkg::RESP_OKAY : cpd_pkg::RESP_SLVERR;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // axi read side
   wire [31:0] rd_mux =
      (s_axi_araddr == ADDR_W'(cpd_pkg::REG_CTRL)) ? {23'h0, in_attention, 3'h0, own_id_r} :
      (s_axi_araddr == ADDR_W'(cpd_pkg::REG_TIMING)) ? {24'h0, wr_dly_r, rd_dly_r} :
      (s_axi_araddr == ADDR_W'(cpd_pkg::REG_STATUS)) ? {27'h0, wr_st_r != cpd_pkg::CPD_IDLE,
         rd_st_r != cpd_pkg::CPD_IDLE, wb_full_r, wb_valid_r, in_attention} :
      (s_axi_araddr == ADDR_W'(cpd_pkg::REG_PRECH)) ? prech_last_r : 32'h0;
   wire rd_ok = s_axi_araddr == ADDR_W'(cpd_pkg::REG_CTRL)
      || s_axi_araddr == ADDR_W'(cpd_pkg::REG_TIMING)
      || s_axi_araddr == ADDR_W'(cpd_pkg::REG_STATUS)
      || s_axi_araddr == ADDR_W'(cpd_pkg::REG_PRECH);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= cpd_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? cpd_pkg::RESP_OKAY : cpd_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_retire_start: assert property (col_go && wb_valid_r && wb_full_r
      |=> !(wb_valid_r && wb_full_r))
      else $error("buffer not retired on start packet");
   a_write_buffer: assert property (c_wr |=> wb_valid_r && !wb_full_r
      && wr_st_r == cpd_pkg::CPD_WAIT)
      else $error("write not buffered");
   a_read_fetch: assert property (c_rd && rd_st_r == cpd_pkg::CPD_IDLE
      |=> rd_load_r ##1 rd_data_r == $past(mem_rdata))
      else $error("read data not fetched");
   a_prech_bank: assert property (c_pre |=> prech_banks[$past(col_s2.column_bank_field)])
      else $error("precharge bank missing");
   a_write_ap_prech: assert property (retire && wb_ap_r |=> prech_banks[$past(wb_bank_r)])
      else $error("write precharge missing");
   a_relax_standby: assert property (c_rlx || x_rlx |=> standby && !in_attention)
      else $error("relax did not reach standby");
   a_mask_apply: assert property (retire && !x_byte_en |-> mem_be == 16'hFFFF)
      else $error("unmasked write lost bytes");
   a_cal_sample: assert property (x_upd |=> cal_drive && cal_sample)
      else $error("sample without drive");
   a_standby_deaf: assert property (!in_attention |-> !retire && !c_rd && !c_wr)
      else $error("packet taken in standby");
   a_read_delay: assert property (c_rd && rd_st_r == cpd_pkg::CPD_IDLE
      |=> rd_cnt_r >= cpd_pkg::RD_DLY_MIN && rd_cnt_r <= cpd_pkg::RD_DLY_MAX)
      else $error("read delay out of range");
   c_read: cover property (rd_start);
   c_masked: cover property (retire && x_byte_en);
   c_relax: cover property (x_rlx && x_pre);
endmodule : cpd_top

// [cpd_pkg.sv]
package cpd_pkg;
   localparam int DEV_W = 5;
   localparam int BANK_W = 5;
   localparam int COL_W = 7;
   localparam int BYTE_W = 8;
   localparam int BEATS = 8;
   localparam int PKT_BYTES = 16;
   localparam int DLY_W = 4;
   localparam int BANKS = 32;

   typedef struct packed {
      logic start;
      logic [4:0] column_device_field;
      logic [3:0] column_opcode;
      logic [4:0] column_bank_field;
      logic [6:0] column_address_field;
   } cpd_col_t;

   typedef struct packed {
      logic mask_select;
      logic [4:0] extended_device_field;
      logic [4:0] extended_bank_field;
      logic [4:0] extended_opcode;
      logic [7:0] lane_b_byte_enables;
      logic [7:0] lane_a_byte_enables;
   } cpd_ext_t;

   typedef enum logic {CPD_STANDBY, CPD_ATTENTION} cpd_pwr_t;
   typedef enum logic [1:0] {CPD_IDLE, CPD_WAIT, CPD_MOVE} cpd_xfer_t;

   localparam logic [2:0] COP_NOOP = 3'h0;
   localparam logic [2:0] COP_WRITE = 3'h1;
   localparam logic [2:0] COP_READ = 3'h3;
   localparam logic [2:0] COP_PRECH = 3'h4;
   localparam logic [2:0] COP_WRITE_AP = 3'h5;
   localparam logic [2:0] COP_READ_AP = 3'h7;
   localparam int COP_RELAX_BIT = 3;
   localparam int XOP_PRECH_BIT = 4;
   localparam int XOP_CAL_BIT = 3;
   localparam int XOP_UPDATE_BIT = 2;
   localparam int XOP_RELAX_BIT = 1;
   localparam int XOP_RSV_BIT = 0;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TIMING = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_PRECH = 8'h0C;
   localparam int CTRL_WAKE_BIT = 8;
   localparam int TIM_WR_LSB = 4;
   localparam logic [4:0] OWN_ID_RST = 5'h00;
   localparam logic [3:0] RD_DLY_RST = 4'h7;
   localparam logic [3:0] WR_DLY_RST = 4'h4;
   localparam logic [3:0] RD_DLY_MIN = 4'h7;
   localparam logic [3:0] RD_DLY_MAX = 4'hC;
   localparam logic [3:0] WR_DLY_MIN = 4'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cpd_pkg

// [cpd_mem.sv]
`timescale 1ns/10ps
module cpd_mem #(
   parameter int AW = 12,
   parameter int NB = 16
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [NB-1:0] be,
   input wire logic [AW-1:0] waddr,
   input wire logic [NB*8-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [NB*8-1:0] rdata
);
   logic [NB*8-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < NB; i++)
      begin
         if (we && be[i])
         begin
            mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
         end
      end
      if (re)
      begin
         rdata <= mem[raddr];
      end
   end
endmodule : cpd_mem

// [cpd_ctrl_model.sv]
`timescale 1ns/10ps
module cpd_ctrl_model (
   input wire logic link_clk,
   output cpd_pkg::cpd_col_t col_pins,
   output cpd_pkg::cpd_ext_t ext_pins,
   output logic [7:0] dq_a,
   output logic [7:0] dq_b
);
   initial
   begin
      col_pins = '0;
      ext_pins = '0;
      dq_a = 8'h00;
      dq_b = 8'h00;
   end

   // packet on the pins for one link cycle, write beats w..w+7 cycles on, n+1 cycles in all
   task automatic pkt(input cpd_pkg::cpd_col_t c, input cpd_pkg::cpd_ext_t e,
      input logic [127:0] d, input int w, input int n);
      for (int j = 0; j <= n; j++)
      begin
         @(negedge link_clk);
         if (j == 0)
         begin
            col_pins <= c;
            ext_pins <= e;
         end
         // released lines flip so a stale packet or beat can never pass for a fresh one
         if (j == 1)
         begin
            col_pins <= cpd_pkg::cpd_col_t'({1'b0, ~c[20:0]});
            ext_pins <= cpd_pkg::cpd_ext_t'(~e);
         end
         if (j >= w && j < w + 8)
         begin
            dq_a <= d[8*(j-w) +: 8];
            dq_b <= d[8*(j-w)+64 +: 8];
         end
         else
         begin
            dq_a <= ~dq_a;
            dq_b <= ~dq_b;
         end
      end
   endtask : pkt
endmodule : cpd_ctrl_model

// [column_packet_decoder_tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
`define POP(q, a) if (q.size() == 0) begin err_count++; \
   $display("unexpected at %0t: stray output", $time); end \
   else begin logic [33:0] v; v = q.pop_front(); `CHK(a, v) end
module column_packet_decoder_tb_top;
   logic aclk = 1'b0;
   logic link_clk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, oe_n, cal_d, cal_s, in_standby;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, prech, pe;
   cpd_pkg::cpd_col_t col;
   cpd_pkg::cpd_ext_t ext, xn, xm, xe;
   logic [7:0] dqa_in, dqb_in, dqa_out, dqb_out;
   int err_count = 0;
   int checks = 0;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [31:0] pq[$];
   logic [1:0] cq[$];
   logic [15:0] dq[$];
   logic [4:0] id, b, bx, dv, xo;
   logic [3:0] dr, dw, op;
   logic [6:0] c;
   logic [127:0] d0, d1, ex;
   logic [15:0] m;
   logic mt, rx;
   logic [9:0] tbl[10] = '{10'h280, 10'h210, 10'h248, 10'h2CC, 10'h201, 10'h211, 10'h09C,
      10'h300, 10'h212, 10'h290};

   always #12.5 aclk = ~aclk;
   initial #7 forever #100 link_clk = ~link_clk;

   cpd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link_clk(link_clk), .col_pins(col), .ext_pins(ext),
      .dq_a_in(dqa_in), .dq_b_in(dqb_in), .dq_a_out(dqa_out), .dq_b_out(dqb_out),
      .dq_oe_n(oe_n), .prech_banks(prech), .cal_drive(cal_d), .cal_sample(cal_s),
      .standby(in_standby));

   cpd_ctrl_model u_ctrl (.link_clk(link_clk), .col_pins(col), .ext_pins(ext),
      .dq_a(dqa_in), .dq_b(dqb_in));

   task automatic wrap_up;
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
   endtask : axi_rd

   task automatic wake;
      axi_wr(cpd_pkg::REG_CTRL, {23'h0, 1'b1, 3'h0, id}, cpd_pkg::RESP_OKAY);
   endtask : wake

   task automatic send(input logic [4:0] dvc, input logic [3:0] o, input logic [4:0] bk,
      input cpd_pkg::cpd_ext_t e, input logic [127:0] d, input int n);
      u_ctrl.pkt({1'b1, dvc, o, bk, c}, e, d, int'(dw), n);
   endtask : send

   always @(posedge aclk)
   begin
      if (bvalid && bready) `POP(bq, bresp)
      if (rvalid && rready) `POP(rq, {rresp, rdata})
      if (aresetn && prech !== 32'h0) `POP(pq, prech)
      if (aresetn && {cal_d, cal_s} !== 2'b00) `POP(cq, {cal_d, cal_s})
   end

   always @(posedge link_clk)
      if (aresetn && oe_n !== 1'b1) `POP(dq, {dqb_out, dqa_out})

   initial
   begin
      #600000;
      err_count++;
      wrap_up();
   end

   initial
   begin
      void'($urandom(18375));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      id = 5'h00;
      dw = cpd_pkg::WR_DLY_RST;
      c = 7'h00;
      axi_rd(cpd_pkg::REG_CTRL, 32'h0, cpd_pkg::RESP_OKAY);
      axi_rd(cpd_pkg::REG_TIMING, {24'h0, cpd_pkg::WR_DLY_RST, cpd_pkg::RD_DLY_RST},
         cpd_pkg::RESP_OKAY);
      axi_rd(8'h10, 32'h0, cpd_pkg::RESP_SLVERR);
      axi_wr(8'h10, 32'hFFFFFFFF, cpd_pkg::RESP_SLVERR);
      `CHK(in_standby, 1'b1)
      // a matching precharge while asleep must leave no pulse behind
      send(5'h00, 4'h4, 5'h03, '0, 128'h0, 3);
      id = 5'($urandom);
      dr = 4'h7 + 4'($urandom % 6);
      dw = 4'h1 + 4'($urandom % 6);
      b = 5'($urandom);
      c = 7'($urandom);
      d0 = {$urandom, $urandom, $urandom, $urandom};
      d1 = {$urandom, $urandom, $urandom, $urandom};
      m = 16'($urandom);
      axi_wr(cpd_pkg::REG_TIMING, {24'h0, dw, dr}, cpd_pkg::RESP_OKAY);
      wake();
      `CHK(in_standby, 1'b0)
      xn = '0;
      xn.extended_device_field = id;
      xm = '0;
      xm.mask_select = 1'b1;
      xm.lane_a_byte_enables = m[7:0];
      xm.lane_b_byte_enables = m[15:8];
      send(id, 4'h1, b, xn, d0, dw + 9);
      send(id, 4'h5, b, xn, d1, dw + 9);
      pq.push_back(32'h1 << b);
      send(~id, 4'h0, 5'h00, xm, 128'h0, 2);
      for (int i = 0; i < 16; i++)
         ex[8*i +: 8] = m[i] ? d1[8*i +: 8] : d0[8*i +: 8];
      for (int k = 0; k < 8; k++)
         dq.push_back({ex[8*k+64 +: 8], ex[8*k +: 8]});
      pq.push_back(32'h1 << b);
      // the tail of this wait keeps the next command clear of the read data
      send(id, 4'h7, b, xn, 128'h0, dr + 10);
      // write to the inverted column ~c, then a read in the very next link cycle
      u_ctrl.pkt({1'b1, id, 4'h1, b, ~c}, xn, 128'h0, 0, 0);
      for (int k = 0; k < 8; k++)
         dq.push_back({ex[8*k+64 +: 8], ex[8*k +: 8]});
      u_ctrl.pkt({1'b1, id, 4'h3, b, c}, xn, d1, int'(dw) - 1, dr + 10);
      foreach (tbl[i])
      begin
         {mt, op, xo} = tbl[i];
         b = 5'($urandom);
         bx = 5'($urandom);
         dv = mt ? id : ~id;
         xe = '0;
         xe.extended_device_field = dv;
         xe.extended_bank_field = bx;
         xe.extended_opcode = xo;
         pe = 32'h0;
         if (mt && op[2:0] == cpd_pkg::COP_PRECH)
            pe[b] = 1'b1;
         if (mt && !xo[0] && xo[4])
            pe[bx] = 1'b1;
         if (pe != 32'h0)
            pq.push_back(pe);
         if (mt && !xo[0] && xo[3])
            cq.push_back({1'b1, xo[2]});
         rx = mt && (op[3] || (xo[1] && !xo[0]));
         send(dv, op, b, xe, 128'h0, 3);
         `CHK(in_standby, rx)
         if (rx)
            wake();
      end
      repeat (20) @(posedge aclk);
      `CHK(pq.size() + cq.size() + dq.size() + rq.size() + bq.size(), 0)
      wrap_up();
   end
endmodule : column_packet_decoder_tb_top
